/* File: otp_defines.svh */
// Constants of the one-time-programmable program memory access block.
// Assumes inclusion by bare name; definitions only.
`ifndef OTP_DEFINES_SVH
`define OTP_DEFINES_SVH

`define OTP_ADDR_W        12
`define OTP_DATA_W        8
`define OTP_DEPTH         4096
`define OTP_TAG_DEPTH     64
`define OTP_BOOT_LAST     12'h002
`define OTP_VEC_FIRST     12'h003
`define OTP_VEC_LAST      12'h011
`define OTP_MBF_FIRST     12'h012
`define OTP_MBF_MAX_LAST  12'h3FF
`define OTP_TOP           12'hFFF
`define OTP_BLANK         8'hFF
`define OTP_OP_STANDBY    4'h0
`define OTP_OP_READ       4'h1
`define OTP_OP_UNLOCK     4'h2
`define OTP_OP_WRITE      4'h3
`define OTP_OP_LOCK       4'h4
`define OTP_OP_TAG_WR     4'h5
`define OTP_OP_LOCK_RD    4'h9
`define OTP_OP_TAG_RD     4'hA
`define OTP_WRITE_NS      10000
`define OTP_OTHER_NS      100
`define OTP_CLK_NS        10
`define OTP_WRITE_CYC     ((`OTP_WRITE_NS + `OTP_CLK_NS - 1) / `OTP_CLK_NS)
`define OTP_OTHER_CYC     ((`OTP_OTHER_NS + `OTP_CLK_NS - 1) / `OTP_CLK_NS)

`endif

/* File: otp_pkg.sv */
// Types of the one-time-programmable program memory access block.
// Assumes otp_defines.svh is on the include path.
`include "otp_defines.svh"

package otp_pkg;

	typedef enum logic [3:0] {
		OP_STANDBY = 4'h0,
		OP_READ    = 4'h1,
		OP_UNLOCK  = 4'h2,
		OP_WRITE   = 4'h3,
		OP_LOCK    = 4'h4,
		OP_TAG_WR  = 4'h5,
		OP_LOCK_RD = 4'h9,
		OP_TAG_RD  = 4'hA
	} op_code_t;

	typedef struct packed {
		logic       rst_addr_n;
		logic       inc_addr;
		logic       rst_conf;
		logic       inc_conf;
		logic       validate_n;
	} prog_pins_t;

	typedef struct packed {
		logic                    we;
		logic [`OTP_ADDR_W-1:0]  addr;
		logic [`OTP_DATA_W-1:0]  wdata;
	} mem_req_t;

endpackage

/* File: otp_pin_sync.sv */
// Three-flop synchroniser with agreement filter for programming pins.
// Assumes pins are asynchronous to CLK_SYS.
`timescale 1ns/100ps
`default_nettype none

module otp_pin_sync #(
	parameter int W   = 5,
	parameter logic [W-1:0] INIT = '0
) (
	// Clock and reset
	input  wire logic         clk,
	input  wire logic         rst_n,
	// Pins in, filtered levels out
	input  wire logic [W-1:0] pin_in,
	output logic      [W-1:0] level_out
);

	logic [W-1:0] s1_q;
	logic [W-1:0] s2_q;
	logic [W-1:0] s3_q;
	logic [W-1:0] lvl_q;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s1_q <= INIT;
			s2_q <= INIT;
			s3_q <= INIT;
		end else begin
			s1_q <= pin_in;
			s2_q <= s1_q;
			s3_q <= s2_q;
		end
	end

	// A change counts only once the second and third flops agree
	genvar i;
	generate
		for (i = 0; i < W; i++) begin : g_bit
			always_ff @(posedge clk or negedge rst_n) begin
				if (!rst_n) begin
					lvl_q[i] <= INIT[i];
				end else if (s2_q[i] == s3_q[i]) begin
					lvl_q[i] <= s3_q[i];
				end
			end
		end
	endgenerate

	assign level_out = lvl_q;

endmodule

`default_nettype wire

/* File: otp_mem.sv */
// Byte-wide program-memory array with registered read data.
// Assumes one access per clock; blank cells read as all ones.
`timescale 1ns/100ps
`default_nettype none
`include "otp_defines.svh"

module otp_mem
	import otp_pkg::*;
#(
	parameter int AW = `OTP_ADDR_W,
	parameter int DW = `OTP_DATA_W
) (
	// Clock
	input  wire logic          clk,
	// Access
	input  wire logic          we,
	input  wire logic [AW-1:0] addr,
	input  wire logic [DW-1:0] wdata,
	output logic      [DW-1:0] rdata
);

	logic [DW-1:0] mem [0:(1<<AW)-1];
	logic [DW-1:0] rdata_q;

	initial begin
		for (int k = 0; k < (1<<AW); k++) begin
			mem[k] = {DW{1'b1}};
		end
	end

	// Programming only clears bits; a one never comes back without erase
	always_ff @(posedge clk) begin
		if (we) begin
			mem[addr] <= mem[addr] & wdata;
		end
	end

	always_ff @(posedge clk) begin
		rdata_q <= mem[addr];
	end

	assign rdata = rdata_q;

endmodule

`default_nettype wire

/* File: otp_prog_access.sv */
// Top of the programming-mode access logic for the program memory.
// Assumes the programmer drives the pins asynchronously to CLK_SYS.
//
// How it works
// - The array holds 4096 bytes selected by a 12-bit address.
// - All data moves over an 8-bit parallel path.
// - Bytes 0 to 2 hold the core's start address.
// - Bytes 3 to 17 are the interrupt vectors, three bytes each.
// - Vertex area runs from 18 to a boundary no higher than 1023.
// - Program area runs from the boundary up to 4095.
// - A 4-bit operation-code register selects the operation.
// - Codes 0,1,2,3,4,5,9,10 are standby, read, unlock, write, lock, tag write, lock read, tag read.
// - A lock cell, once programmed, shuts out external operations other than tag and lock reads.
// - A software version tag can be written and read back.
// - Address reset low clears address and unlock flag; increment edge adds one.
// - Config reset clears the code, config edge adds one; high config reset drives data out.
// - Unlock only works while the lock cell is one; once locked only tag and lock reads work.
`timescale 1ns/100ps
`default_nettype none
`include "otp_defines.svh"

module otp_prog_access
	import otp_pkg::*;
#(
	parameter int          ADDR_W    = `OTP_ADDR_W,
	parameter int          DATA_W    = `OTP_DATA_W,
	parameter int          TAG_DEPTH = `OTP_TAG_DEPTH,
	parameter int          WRITE_CYC = `OTP_WRITE_CYC,
	parameter int          OTHER_CYC = `OTP_OTHER_CYC,
	parameter logic [11:0] AREA_BOUNDARY = `OTP_MBF_MAX_LAST
) (
	// Clock and reset
	input  wire logic              CLK_SYS,
	input  wire logic              RST_N,
	// Programming control pins
	input  wire logic              RST_ADDR_N,
	input  wire logic              INC_ADDR,
	input  wire logic              RST_CONF,
	input  wire logic              INC_CONF,
	input  wire logic              VALIDATE_N,
	// Data port, split two-way pin
	input  wire logic [DATA_W-1:0] DATA_IN,
	output logic      [DATA_W-1:0] DATA_OUT,
	output logic      [DATA_W-1:0] DATA_OE,
	// Status
	output logic                   UNLOCKED,
	output logic                   LOCK_CELL,
	output logic [ADDR_W-1:0]      ADDR,
	output logic [3:0]             OP_CODE,
	output logic                   AREA_ERR,
	output logic [1:0]             AREA
);

	////////////////////////////////////////////////////////////////////////
	// Pin synchronisation

	prog_pins_t pins_raw;
	prog_pins_t pins;
	prog_pins_t pins_prev_q;
	logic [DATA_W-1:0] din_q;

	assign pins_raw = '{rst_addr_n: RST_ADDR_N, inc_addr: INC_ADDR,
		rst_conf: RST_CONF, inc_conf: INC_CONF, validate_n: VALIDATE_N};

	otp_pin_sync #(
		.W    (5),
		.INIT (5'h11)
	) u_sync (
		.clk       (CLK_SYS),
		.rst_n     (RST_N),
		.pin_in    (pins_raw),
		.level_out (pins)
	);

	// Data pins are as asynchronous as the control pins, so they get the
	// same three-flop filter; a byte caught mid-change never reaches a cell
	otp_pin_sync #(
		.W    (DATA_W),
		.INIT ('0)
	) u_data_sync (
		.clk       (CLK_SYS),
		.rst_n     (RST_N),
		.pin_in    (DATA_IN),
		.level_out (din_q)
	);

	always_ff @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N) begin
			pins_prev_q <= 5'h11;
		end else begin
			pins_prev_q <= pins;
		end
	end

	logic inc_addr_rise;
	logic inc_conf_rise;
	logic val_fall;
	logic val_rise;

	assign inc_addr_rise = pins.inc_addr & ~pins_prev_q.inc_addr;
	assign inc_conf_rise = pins.inc_conf & ~pins_prev_q.inc_conf;
	assign val_fall      = ~pins.validate_n & pins_prev_q.validate_n;
	assign val_rise      = pins.validate_n & ~pins_prev_q.validate_n;

	////////////////////////////////////////////////////////////////////////
	// Address and operation-code registers

	logic [ADDR_W-1:0] addr_q;
	logic [3:0]        op_q;

	// The level clear wins over an increment edge in the same cycle
	// Address wraps past the top cell like any 12-bit counter
	always_ff @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N) begin
			addr_q <= 12'h000;
		end else if (!pins.rst_addr_n) begin
			addr_q <= 12'h000;
		end else if (inc_addr_rise) begin
			addr_q <= addr_q + 12'h001;
		end
	end

	// Config reset wins over an increment edge in the same cycle
	always_ff @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N) begin
			op_q <= 4'h0;
		end else if (pins.rst_conf) begin
			op_q <= 4'h0;
		end else if (inc_conf_rise) begin
			op_q <= op_q + 4'h1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Validate pulse width measurement

	// The programmer owns pulse width; short pulses are ignored as glitches
	// Counter saturates so a held-low validate never wraps to a short pulse
	logic [15:0] low_cnt_q;
	logic        pulse_ok;
	logic        write_ok;

	always_ff @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N) begin
			low_cnt_q <= 16'h0000;
		end else if (val_fall) begin
			low_cnt_q <= 16'h0001;
		end else if (!pins.validate_n && low_cnt_q != 16'hFFFF) begin
			low_cnt_q <= low_cnt_q + 16'h0001;
		end
	end

	assign pulse_ok = low_cnt_q >= 16'(OTHER_CYC);
	assign write_ok = low_cnt_q >= 16'(WRITE_CYC);

	////////////////////////////////////////////////////////////////////////
	// Operation execution

	logic              unlock_q;
	logic              lock_cell_q;
	logic [DATA_W-1:0] tag_q [0:TAG_DEPTH-1];
	logic [DATA_W-1:0] dout_q;
	logic [DATA_W-1:0] mem_rdata;
	logic              mem_we;
	logic              do_op;
	logic [5:0]        tag_idx;
	logic              op_known;
	logic              may_modify;
	mem_req_t          mem_req;

	// Codes that carry meaning; anything else is treated as standby
	always_comb begin
		case (op_q)
			OP_STANDBY, OP_READ, OP_UNLOCK, OP_WRITE,
			OP_LOCK, OP_TAG_WR, OP_LOCK_RD, OP_TAG_RD: begin
				op_known = 1'b1;
			end
			default: begin
				op_known = 1'b0;
			end
		endcase
	end

	// One term for every change to cells or lock keeps the gates in step
	assign may_modify = unlock_q & lock_cell_q;
	assign do_op      = val_rise & pulse_ok & op_known;
	assign tag_idx    = addr_q[5:0];

	// Writes honoured only when unlocked and the lock cell is intact
	always_comb begin
		mem_we = 1'b0;
		if (do_op && may_modify && op_q == OP_WRITE && write_ok) begin
			mem_we = 1'b1;
		end
	end

	assign mem_req = '{we: mem_we, addr: addr_q, wdata: din_q};

	otp_mem #(
		.AW (ADDR_W),
		.DW (DATA_W)
	) u_mem (
		.clk   (CLK_SYS),
		.we    (mem_req.we),
		.addr  (mem_req.addr),
		.wdata (mem_req.wdata),
		.rdata (mem_rdata)
	);

	always_ff @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N) begin
			unlock_q <= 1'b0;
		end else if (!pins.rst_addr_n) begin
			// The level clear wins over an unlock landing in the same cycle
			unlock_q <= 1'b0;
		end else if (do_op && op_q == OP_UNLOCK && lock_cell_q) begin
			unlock_q <= 1'b1;
		end
	end

	// Lock cell is set back to one by RST_N; otherwise only the lock operation clears it
	always_ff @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N) begin
			lock_cell_q <= 1'b1;
		end else if (do_op && op_q == OP_LOCK && may_modify) begin
			lock_cell_q <= 1'b0;
		end
	end

	// Version tag: tag writes only clear bits; RST_N sets the cells back to blank
	genvar g;
	generate
		for (g = 0; g < TAG_DEPTH; g++) begin : g_tag
			always_ff @(posedge CLK_SYS or negedge RST_N) begin
				if (!RST_N) begin
					tag_q[g] <= `OTP_BLANK;
				end else if (do_op && op_q == OP_TAG_WR && may_modify
						&& tag_idx == 6'(g)) begin
					tag_q[g] <= tag_q[g] & din_q;
				end
			end
		end
	endgenerate

	// Result latch; codes without meaning fall to the default
	always_ff @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N) begin
			dout_q <= 8'h00;
		end else if (pins.rst_conf) begin
			dout_q <= dout_q;
		end else begin
			case (op_q)
				OP_READ: begin
					if (unlock_q && lock_cell_q) begin
						dout_q <= mem_rdata;
					end
				end
				OP_UNLOCK,
				OP_LOCK_RD: begin
					dout_q <= {7'h00, lock_cell_q};
				end
				OP_TAG_RD: begin
					dout_q <= tag_q[tag_idx];
				end
				OP_WRITE: begin
					if (do_op) begin
						dout_q <= 8'h00;
					end
				end
				default: begin
					dout_q <= dout_q;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Memory area decode

	// Boundary is a parameter since the fuzzy area size is per program
	always_ff @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N) begin
			AREA <= 2'h0;
		end else if (addr_q <= `OTP_BOOT_LAST) begin
			AREA <= 2'h0;
		end else if (addr_q <= `OTP_VEC_LAST) begin
			AREA <= 2'h1;
		end else if (addr_q < AREA_BOUNDARY) begin
			AREA <= 2'h2;
		end else begin
			AREA <= 2'h3;
		end
	end

	assign AREA_ERR = (AREA_BOUNDARY > `OTP_MBF_MAX_LAST + 12'h001)
		|| (AREA_BOUNDARY < `OTP_MBF_FIRST);

	////////////////////////////////////////////////////////////////////////
	// Outputs

	assign DATA_OUT  = dout_q;
	// Filtered level, so the port turns round only once the pin has settled
	assign DATA_OE   = {DATA_W{pins.rst_conf}};
	assign UNLOCKED  = unlock_q;
	assign LOCK_CELL = lock_cell_q;
	assign ADDR      = addr_q;
	assign OP_CODE   = op_q;

endmodule

`default_nettype wire

/* File: otp_prog_checker.sv */
// Port assertions for otp_prog_access.
// Assumes a bind from the bench top file.
`timescale 1ns/100ps
`default_nettype none

module otp_prog_checker
	import otp_pkg::*;
#(
	parameter logic [11:0] AREA_BOUNDARY = 12'h3FF
) (
	// Clock and reset
	input wire logic        CLK_SYS,
	input wire logic        RST_N,
	// Pins
	input wire logic        RST_ADDR_N,
	input wire logic        RST_CONF,
	input wire logic        VALIDATE_N,
	// Results
	input wire logic [7:0]  DATA_OUT,
	input wire logic [7:0]  DATA_OE,
	input wire logic        UNLOCKED,
	input wire logic        LOCK_CELL,
	input wire logic [11:0] ADDR,
	input wire logic [3:0]  OP_CODE,
	input wire logic [1:0]  AREA
);
	logic [1:0] exp_area;

	// Boundary itself is left out: either reading of it is plausible
	assign exp_area = (ADDR <= 12'h002) ? 2'h0 :
		(ADDR <= 12'h011) ? 2'h1 :
		(ADDR < AREA_BOUNDARY) ? 2'h2 : 2'h3;

	default clocking cb @(posedge CLK_SYS);
	endclocking
	default disable iff (!RST_N);

	////////////////////////////////////////////////////////////////////////
	chk_oe_on: assert property ($rose(RST_CONF) |-> ##[2:7] DATA_OE == 8'hFF)
		else $error("data port not driven");
	chk_oe_off: assert property ($fell(RST_CONF) |-> ##[2:7] DATA_OE == 8'h00)
		else $error("data port not released");
	chk_addr_clear: assert property ((!RST_ADDR_N)[*8] |-> ADDR == 12'h000 && !UNLOCKED)
		else $error("address reset failed");
	chk_addr_step: assert property (ADDR != $past(ADDR) |-> ADDR == $past(ADDR) + 12'h001 || ADDR == 12'h000)
		else $error("address jumped");
	chk_code_step: assert property (OP_CODE != $past(OP_CODE) |-> OP_CODE == $past(OP_CODE) + 4'h1 || OP_CODE == 4'h0)
		else $error("op code jumped");
	chk_code_clear: assert property (RST_CONF[*8] |-> OP_CODE == 4'h0)
		else $error("op code not cleared");
	chk_unlock_cause: assert property ($rose(UNLOCKED) |-> LOCK_CELL && OP_CODE == 4'h2)
		else $error("unlock without cause");
	chk_lock_cause: assert property ($fell(LOCK_CELL) |-> $past(UNLOCKED) && OP_CODE == 4'h4)
		else $error("lock without cause");
	chk_lock_sticky: assert property (!LOCK_CELL |=> !LOCK_CELL)
		else $error("lock cell came back");
	chk_status_read: assert property ($rose(VALIDATE_N) && OP_CODE == 4'h9 |-> ##[3:10] DATA_OUT == {7'h00, LOCK_CELL})
		else $error("lock status read wrong");
	chk_area_map: assert property ($stable(ADDR) && ADDR != AREA_BOUNDARY |-> AREA == exp_area)
		else $error("area wrong");
endmodule
`default_nettype wire

/* File: otp_programmer.sv */
// Behavioural programmer on the pins.
// Assumes tasks are entered at a falling edge.
`timescale 1ns/100ps
`default_nettype none

module otp_programmer
	import otp_pkg::*;
(
	// Clock
	input  wire logic      clk,
	// Pins
	output var prog_pins_t pins,
	output var logic [7:0] data_in
);
	initial begin
		pins = '{1'b1, 1'b0, 1'b0, 1'b0, 1'b1};
		data_in = 8'h5A;
	end

	////////////////////////////////////////////////////////////////////////
	// Most levels held 8 cycles so the pin filter settles; validate low is held for n cycles
	task automatic hold(input int n);
		repeat (n) @(negedge clk);
	endtask

	task automatic set_data(input logic [7:0] d);
		data_in = d;
	endtask

	// Released bus shows the inverse, never a stale value
	task automatic show();
		pins.rst_conf = 1'b1;
		data_in = ~data_in;
		hold(8);
	endtask

	task automatic load(input logic [3:0] c);
		show();
		pins.rst_conf = 1'b0;
		hold(8);
		repeat (c) begin
			pins.inc_conf = 1'b1;
			hold(8);
			pins.inc_conf = 1'b0;
			hold(8);
		end
	endtask

	task automatic fire(input int n);
		pins.validate_n = 1'b0;
		hold(n);
		pins.validate_n = 1'b1;
		hold(8);
	endtask

	task automatic step();
		pins.inc_addr = 1'b1;
		hold(8);
		pins.inc_addr = 1'b0;
		hold(8);
	endtask

	task automatic clear_addr();
		pins.rst_addr_n = 1'b0;
		hold(8);
		pins.rst_addr_n = 1'b1;
		hold(8);
	endtask
endmodule
`default_nettype wire

/* File: otp_tb.sv */
// Self-checking bench for otp_prog_access.
// Assumes otp_programmer drives the pins.
`timescale 1ns/100ps
`default_nettype none

module testbench
	import otp_pkg::*;
;
	localparam logic [11:0] BOUND = 12'h028;
	localparam int WR = 20;
	logic        clk, rst_n, unlocked, lock_cell, area_err;
	prog_pins_t  pins;
	logic [7:0]  data_in, data_out, data_oe;
	logic [11:0] addr;
	logic [3:0]  op_code;
	logic [1:0]  area;
	int          err_total, n_compared, cyc, unl, lck, adr;
	int          mem_m[4096], tag_m[64];
	int          spare[9] = '{0, 6, 7, 8, 11, 12, 13, 14, 15};

	otp_programmer prog_u (.clk(clk), .pins(pins), .data_in(data_in));
	otp_prog_access #(.WRITE_CYC(WR), .OTHER_CYC(2), .AREA_BOUNDARY(BOUND)) dut_u (
		.CLK_SYS(clk), .RST_N(rst_n), .RST_ADDR_N(pins.rst_addr_n),
		.INC_ADDR(pins.inc_addr), .RST_CONF(pins.rst_conf),
		.INC_CONF(pins.inc_conf), .VALIDATE_N(pins.validate_n),
		.DATA_IN(data_in), .DATA_OUT(data_out), .DATA_OE(data_oe),
		.UNLOCKED(unlocked), .LOCK_CELL(lock_cell), .ADDR(addr),
		.OP_CODE(op_code), .AREA_ERR(area_err), .AREA(area));

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	always @(posedge clk) begin
		cyc++;
		if (cyc == 90000) begin
			err_total++;
			give_verdict();
		end
	end

	////////////////////////////////////////////////////////////////////////
	task automatic give_verdict();
		$display("compared %0d, mismatches %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	task automatic chk(input logic [11:0] got, input int exp);
		n_compared++;
		if (got !== 12'(exp)) begin
			err_total++;
			$display("wrong value at %0t: got %h, want %h", $time, got, exp);
		end
	endtask

	function automatic int area_of(input int a);
		if (a <= 2) return 0;
		if (a <= 17) return 1;
		return (a < BOUND) ? 2 : 3;
	endfunction

	// One operation, then the model is updated and compared
	task automatic op(input int c, input int n, input logic [7:0] d);
		prog_u.load(4'(c));
		chk(12'(op_code), c);
		prog_u.set_data(d);
		prog_u.fire(n);
		if (unl && lck) begin
			if (c == 3 && n >= WR) mem_m[adr] &= d;
			if (c == 4) lck = 0;
			if (c == 5) tag_m[adr % 64] &= d;
		end
		if (c == 2 && lck) unl = 1;
		chk(12'(lock_cell), lck);
		if (lck) chk(12'(unlocked), unl);
		chk(addr, adr);
		if (c == 1 && unl && lck) chk(12'(data_out), mem_m[adr]);
		if (c == 2 || c == 9) chk(12'(data_out), lck);
		if (c == 10) chk(12'(data_out), tag_m[adr % 64]);
	endtask

	initial begin
		rst_n = 1'b0;
		lck = 1;
		foreach (mem_m[i]) mem_m[i] = 8'hFF;
		foreach (tag_m[i]) tag_m[i] = 8'hFF;
		void'($urandom(32'h61b1));
		repeat (2) @(negedge clk);
		rst_n = 1'b1;
		prog_u.hold(2);
		chk(12'(op_code), 0);
		chk(12'(lock_cell), 1);
		chk(12'(data_oe), 0);
		chk(12'(area_err), 0);
		op(3, 40, 8'h00);
		op(2, 10, 8'h00);
		op(1, 10, 8'h00);
		$display("test reset and refusal done");
		for (int a = 0; a < 46; a++) begin
			if (a % 4 == 0) begin
				op(3, 30, 8'($urandom));
				op(3, 30, 8'($urandom));
				op(3, 5, 8'h00);
				op(1, 10, 8'h00);
				prog_u.show();
				chk(12'(data_oe), 8'hFF);
				chk(12'(data_out), mem_m[adr]);
			end
			prog_u.step();
			adr++;
			if (adr != BOUND) chk(12'(area), area_of(adr));
		end
		$display("test write walk done");
		op(5, 10, 8'($urandom));
		op(10, 10, 8'h00);
		foreach (spare[i]) begin
			op(spare[i], 10, 8'h00);
			op(1, 10, 8'h00);
		end
		$display("test spare codes done");
		op(9, 10, 8'h00);
		op(4, 10, 8'h00);
		op(10, 10, 8'h00);
		prog_u.clear_addr();
		unl = 0;
		adr = 0;
		chk(12'(unlocked), 0);
		op(2, 10, 8'h00);
		chk(12'(unlocked), 0);
		op(5, 10, 8'h00);
		op(10, 10, 8'h00);
		$display("test lock done");
		give_verdict();
	end
endmodule

bind otp_prog_access otp_prog_checker #(.AREA_BOUNDARY(AREA_BOUNDARY)) chk_u (
	.CLK_SYS(CLK_SYS), .RST_N(RST_N), .RST_ADDR_N(RST_ADDR_N),
	.RST_CONF(RST_CONF), .VALIDATE_N(VALIDATE_N), .DATA_OUT(DATA_OUT),
	.DATA_OE(DATA_OE), .UNLOCKED(UNLOCKED), .LOCK_CELL(LOCK_CELL),
	.ADDR(ADDR), .OP_CODE(OP_CODE), .AREA(AREA));
`default_nettype wire
